// >>> common/acr_regs.vh
// constants of the main control register bank
// assumes plain verilog-2005 and inclusion by bare name
`ifndef ACR_REGS_VH
`define ACR_REGS_VH
`define ACR_MAIN_ADDR      8'h18
`define ACR_AUX_ADDR       8'h19
`define ACR_RATE_ADDR      8'h1a
`define ACR_RESULT_ADDR    8'h0c
`define ACR_MAIN_RESET     8'h00
`define ACR_AUX_RESET      8'h3f
`define ACR_RATE_RESET     8'h98
`define ACR_SAMPLE_RESET   4'h2
`define ACR_RESULT_SET     8'haa
`define ACR_RESULT_READ    8'h55
`define ACR_OPERATE_BIT    7
`define ACR_PERF_BIT       6
`define ACR_NEWSMP_BIT     5
`define ACR_RANGE_HI_BIT   4
`define ACR_RANGE_LO_BIT   3
`define ACR_TAP_BIT        2
`define ACR_MOTION_BIT     1
`define ACR_ORIENT_BIT     0
`define ACR_REBOOT_BIT     7
`define ACR_TEST_BIT       6
`define ACR_MASK_MSB       5
`define ACR_MASK_LSB       0
`define ACR_ORATE_MSB      7
`define ACR_ORATE_LSB      6
`define ACR_KRATE_MSB      5
`define ACR_KRATE_LSB      3
`define ACR_MRATE_MSB      2
`define ACR_MRATE_LSB      0
`define ACR_REBOOT_NS      1000
`define ACR_REBOOT_CYCLES  ((`ACR_REBOOT_NS + 9) / 10)
`endif

// >>> design/acr_main_control.v
// main control register bank: operate switch, modes, engine enables, rates
// assumes a serial interface front end giving one-cycle read and write strobes
`timescale 1ns/1ps
`include "acr_regs.vh"
module acr_main_control #(
  parameter REBOOT_CYCLES = `ACR_REBOOT_CYCLES
)(
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWrite,
  input  wire       regRead,
  input  wire [3:0] sampleRateField,
  input  wire       newSampleEvent,
  input  wire [5:0] tiltEvent,
  output reg  [7:0] regRdata,
  output reg        acquireActive,
  output reg        highResolution,
  output reg  [1:0] rangeSelect,
  output reg        tapEngineRun,
  output reg        motionEngineRun,
  output reg        orientationRun,
  output reg        newSampleIrq,
  output reg        tiltIrq,
  output reg  [5:0] tiltMask,
  output reg  [1:0] orientationRate,
  output reg  [2:0] knockRate,
  output reg  [2:0] motionRate,
  output reg  [3:0] sampleRateSel,
  output reg        rebootBusy
);
  // reset images, sized so that their fields can be sliced
  localparam [7:0]   MAIN_RESET   = `ACR_MAIN_RESET;
  localparam [7:0]   AUX_RESET    = `ACR_AUX_RESET;
  localparam [7:0]   RATE_RESET   = `ACR_RATE_RESET;
  localparam [7:0]   RESULT_IDLE  = `ACR_RESULT_READ;
  localparam [7:0]   RESULT_ARMED = `ACR_RESULT_SET;
  localparam integer REBOOT_INT   = REBOOT_CYCLES;
  localparam [15:0]  REBOOT_LOAD  = REBOOT_INT[15:0];
  localparam         RB_IDLE      = 1'b0;
  localparam         RB_COUNT     = 1'b1;

  reg  [7:0]  mainControl;
  reg  [7:0]  auxControl;
  reg  [7:0]  engineRateControl;
  reg  [7:0]  commandTestResult;
  reg  [15:0] rebootCount;
  reg         rebootState;
  reg  [7:0]  next_rdata;

  // one address compare shared by every strobe decode
  function isAddr;
    input [7:0] addr;
    input [7:0] target;
    begin
      isAddr = (addr == target);
    end
  endfunction

  // an engine runs only while the bank is operating
  function runGate;
    input operate;
    input enable;
    begin
      runGate = operate & enable;
    end
  endfunction

  wire writeMain  = regWrite && isAddr(regAddr, `ACR_MAIN_ADDR);
  wire writeAux   = regWrite && isAddr(regAddr, `ACR_AUX_ADDR);
  wire writeRate  = regWrite && isAddr(regAddr, `ACR_RATE_ADDR);
  wire readResult = regRead && isAddr(regAddr, `ACR_RESULT_ADDR);
  wire rebootDone = (rebootState == RB_COUNT) && (rebootCount == 16'h0000);
  wire operating  = mainControl[`ACR_OPERATE_BIT];
  wire testArmed  = auxControl[`ACR_TEST_BIT];

  // soft reboot sequencer; busy stays up REBOOT_CYCLES + 1 cycles
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rebootState <= RB_IDLE;
      rebootBusy  <= 1'b0;
      rebootCount <= 16'h0000;
    end
    else
    begin
      case (rebootState)
        RB_IDLE:
        begin
          if (writeAux && regWdata[`ACR_REBOOT_BIT])
          begin
            rebootState <= RB_COUNT;
            rebootBusy  <= 1'b1;
            rebootCount <= REBOOT_LOAD;
          end
        end
        RB_COUNT:
        begin
          if (rebootCount == 16'h0000)
          begin
            // busy drops on the same edge as the restore below
            rebootState <= RB_IDLE;
            rebootBusy  <= 1'b0;
          end
          else
            rebootCount <= rebootCount - 16'h0001;
        end
        default:
        begin
          rebootState <= RB_IDLE;
          rebootBusy  <= 1'b0;
        end
      endcase
    end
  end

  // register storage; writes are refused while a reboot runs
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mainControl       <= MAIN_RESET;
      auxControl        <= AUX_RESET;
      engineRateControl <= RATE_RESET;
      commandTestResult <= RESULT_IDLE;
    end
    else if (rebootDone)
    begin
      // restore on the same edge as the busy bit drops
      mainControl       <= MAIN_RESET;
      auxControl        <= AUX_RESET;
      engineRateControl <= RATE_RESET;
      commandTestResult <= RESULT_IDLE;
    end
    else if (rebootState == RB_IDLE)
    begin
      // writes taken as given; staying in standby is the host's duty
      if (writeMain)
        mainControl <= regWdata;
      if (writeRate)
        engineRateControl <= regWdata;
      if (writeAux)
      begin
        // the reboot bit is not stored; it reads back the sequencer
        auxControl <= {1'b0, regWdata[6:0]};
        if (regWdata[`ACR_TEST_BIT])
          commandTestResult <= RESULT_ARMED;
      end
      else if (readResult && testArmed)
      begin
        // a write in the same cycle wins over the clearing read
        auxControl[`ACR_TEST_BIT] <= 1'b0;
        commandTestResult         <= RESULT_IDLE;
      end
    end
  end

  always @*
  begin
    case (regAddr)
      `ACR_MAIN_ADDR:   next_rdata = mainControl;
      `ACR_AUX_ADDR:    next_rdata = {rebootBusy, auxControl[6:0]};
      `ACR_RATE_ADDR:   next_rdata = engineRateControl;
      `ACR_RESULT_ADDR: next_rdata = commandTestResult;
      default:          next_rdata = 8'h00;
    endcase
  end

  // outputs registered from the stored fields; sampleRateSel from the sampleRateField input, the two irqs also from the event inputs
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regRdata        <= 8'h00;
      acquireActive   <= 1'b0;
      highResolution  <= 1'b0;
      rangeSelect     <= 2'h0;
      tapEngineRun    <= 1'b0;
      motionEngineRun <= 1'b0;
      orientationRun  <= 1'b0;
      newSampleIrq    <= 1'b0;
      tiltIrq         <= 1'b0;
      tiltMask        <= AUX_RESET[`ACR_MASK_MSB:`ACR_MASK_LSB];
      orientationRate <= RATE_RESET[`ACR_ORATE_MSB:`ACR_ORATE_LSB];
      knockRate       <= RATE_RESET[`ACR_KRATE_MSB:`ACR_KRATE_LSB];
      motionRate      <= RATE_RESET[`ACR_MRATE_MSB:`ACR_MRATE_LSB];
      sampleRateSel   <= `ACR_SAMPLE_RESET;
    end
    else
    begin
      regRdata        <= regRead ? next_rdata : 8'h00;
      acquireActive   <= operating;
      highResolution  <= mainControl[`ACR_PERF_BIT];
      // code 11 is undefined; passed through unchanged
      rangeSelect     <= mainControl[`ACR_RANGE_HI_BIT:`ACR_RANGE_LO_BIT];
      tapEngineRun    <= runGate(operating, mainControl[`ACR_TAP_BIT]);
      motionEngineRun <= runGate(operating, mainControl[`ACR_MOTION_BIT]);
      orientationRun  <= runGate(operating, mainControl[`ACR_ORIENT_BIT]);
      newSampleIrq    <= operating && mainControl[`ACR_NEWSMP_BIT] && newSampleEvent;
      tiltIrq         <= orientationRun && |(tiltEvent & auxControl[`ACR_MASK_MSB:0]);
      tiltMask        <= auxControl[`ACR_MASK_MSB:0];
      orientationRate <= engineRateControl[`ACR_ORATE_MSB:`ACR_ORATE_LSB];
      knockRate       <= engineRateControl[`ACR_KRATE_MSB:`ACR_KRATE_LSB];
      motionRate      <= engineRateControl[`ACR_MRATE_MSB:`ACR_MRATE_LSB];
      sampleRateSel   <= sampleRateField;
    end
  end
endmodule // acr_main_control

// >>> verif/acr_host.sv
// host model: one-cycle write and read strobes
// assumes the bank samples strobes on rising sys_clk
`timescale 1ns/1ps
module acr_host (
  input  wire       sys_clk,
  output reg  [7:0] regAddr,
  output reg  [7:0] regWdata,
  output reg        regWrite,
  output reg        regRead
);
  initial {regAddr, regWdata, regWrite, regRead} = 18'h0;
  task acc(input rw, input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= rw;
      regRead <= !rw;
      @(posedge sys_clk);
      {regWrite, regRead} <= 2'h0;
      #1;
    end
  endtask
endmodule // acr_host

// >>> verif/acr_main_control_sva.sv
// checker on the control bank ports
// assumes the bench sets REBOOT_CYCLES to 4
`timescale 1ns/1ps
module acr_main_control_sva #(parameter REBOOT_CYCLES = 4) (
  input wire       sys_clk,
  input wire       reset_n,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire       regWrite,
  input wire       regRead,
  input wire [3:0] sampleRateField,
  input wire       newSampleEvent,
  input wire [5:0] tiltEvent,
  input wire [7:0] regRdata,
  input wire       acquireActive,
  input wire       orientationRun,
  input wire       newSampleIrq,
  input wire       tiltIrq,
  input wire [5:0] tiltMask,
  input wire [3:0] sampleRateSel,
  input wire       rebootBusy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // busy spans REBOOT_CYCLES + 1 cycles
  sequence busy_s; rebootBusy [*5] ##1 !rebootBusy; endsequence
  sequence restored_s; tiltMask == 6'h3f && !acquireActive; endsequence
  reboot_len_a: assert property ($rose(rebootBusy) |-> busy_s)
    else $error("reboot length");
  reboot_go_a: assert property (regWrite && regAddr == 8'h19 && regWdata[7] |=> rebootBusy)
    else $error("reboot start");
  reboot_clear_a: assert property ($fell(rebootBusy) |-> ##2 restored_s)
    else $error("reboot restore");
  orient_gate_a: assert property (orientationRun |-> acquireActive)
    else $error("orientation run");
  sample_irq_a: assert property (newSampleIrq |-> $past(newSampleEvent) && acquireActive)
    else $error("sample irq");
  tilt_irq_a: assert property (tiltIrq |-> $past(tiltEvent) != 6'h0 && orientationRun)
    else $error("tilt irq");
  result_read_a: assert property (regRead && regAddr == 8'h0c |=> regRdata inside {8'haa, 8'h55})
    else $error("result read");
  rate_copy_a: assert property (1'b1 |=> sampleRateSel == $past(sampleRateField))
    else $error("rate copy");
endmodule // acr_main_control_sva
bind acr_main_control acr_main_control_sva #(.REBOOT_CYCLES(REBOOT_CYCLES)) i_sva (.sys_clk,
  .reset_n, .regAddr, .regWdata, .regWrite, .regRead, .sampleRateField, .newSampleEvent,
  .tiltEvent, .regRdata, .acquireActive, .orientationRun, .newSampleIrq, .tiltIrq, .tiltMask,
  .sampleRateSel, .rebootBusy);

// >>> verif/accel_main_control_regs_test.sv
// random and corner bench for the control bank
// assumes host model and checker beside it
`timescale 1ns/1ps
module accel_main_control_regs_test;
  reg         sys_clk = 1'b0, reset_n = 1'b0, newSampleEvent = 1'b0;
  reg  [3:0]  sampleRateField = 4'h2;
  reg  [5:0]  tiltEvent = 6'h0;
  reg  [15:0] rnd = 16'd1349;
  reg  [7:0]  c, r, m;
  wire [7:0]  regAddr, regWdata, regRdata;
  wire        regWrite, regRead, acquireActive, highResolution, tapEngineRun;
  wire        motionEngineRun, orientationRun, newSampleIrq, tiltIrq, rebootBusy;
  wire [5:0]  tiltMask;
  wire [1:0]  rangeSelect, orientationRate;
  wire [2:0]  knockRate, motionRate;
  wire [3:0]  sampleRateSel;
  integer     numErrors = 0, comparisons = 0, n, w;
  always #5 sys_clk = ~sys_clk;
  acr_host i_acr_host (.sys_clk, .regAddr, .regWdata, .regWrite, .regRead);
  acr_main_control #(.REBOOT_CYCLES(4)) i_acr_main_control (.sys_clk, .reset_n, .regAddr,
    .regWdata, .regWrite, .regRead, .sampleRateField, .newSampleEvent, .tiltEvent, .regRdata,
    .acquireActive, .highResolution, .rangeSelect, .tapEngineRun, .motionEngineRun,
    .orientationRun, .newSampleIrq, .tiltIrq, .tiltMask, .orientationRate, .knockRate,
    .motionRate, .sampleRateSel, .rebootBusy);
  function [15:0] step(input [15:0] s);
    step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [7:0] runs(input [7:0] v);
    runs = {5'h0, v[2:0] & {3{v[7]}}};
  endfunction
  task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
        numErrors = numErrors + 1;
        $display("mismatch %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      i_acr_host.acc(1'b0, a, 8'h0);
      chk("rdata", regRdata, e);
    end
  endtask
  task results;
    begin
      if (numErrors == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    numErrors = numErrors + 1;
    results;
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h3f);
    rd(8'h1a, 8'h98);
    rd(8'h0c, 8'h55);
    rd(8'h33, 8'h00);
    chk("srate", sampleRateSel, 8'h02);
    for (n = 0; n < 14; n = n + 1)
    begin
      rnd = step(step(rnd));
      c = (n < 2) ? {8{n[0]}} : rnd[7:0];
      r = (n < 2) ? {8{n[0]}} : rnd[15:8];
      m = r & 8'h3f;
      sampleRateField <= r[3:0];
      i_acr_host.acc(1'b1, 8'h18, 8'h00);
      repeat (2) @(posedge sys_clk);
      i_acr_host.acc(1'b1, 8'h19, m);
      i_acr_host.acc(1'b1, 8'h1a, r);
      i_acr_host.acc(1'b1, 8'h18, c);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("mode", {acquireActive, highResolution, rangeSelect}, {c[7:6], c[4:3]});
      chk("run", {tapEngineRun, motionEngineRun, orientationRun}, runs(c));
      chk("rates", {orientationRate, knockRate, motionRate}, r);
      chk("mask", tiltMask, m);
      chk("srate", sampleRateSel, r[3:0]);
      @(posedge sys_clk);
      newSampleEvent <= 1'b1;
      tiltEvent <= r[7:2];
      @(posedge sys_clk);
      newSampleEvent <= 1'b0;
      tiltEvent <= 6'h0;
      #1;
      chk("irq", {newSampleIrq, tiltIrq}, {c[7] & c[5], c[7] & c[0] & |(r[7:2] & m)});
    end
    i_acr_host.acc(1'b1, 8'h18, 8'h7f);
    i_acr_host.acc(1'b1, 8'h19, 8'h40 | m);
    rd(8'h0c, 8'haa);
    rd(8'h19, m);
    rd(8'h0c, 8'h55);
    i_acr_host.acc(1'b1, 8'h19, 8'h80);
    // negedge polling avoids racing the busy update
    for (w = 0; w < 20 && rebootBusy !== 1'b0; w = w + 1) @(negedge sys_clk);
    chk("rbwait", w[7:0], 8'h06);
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h3f);
    rd(8'h1a, 8'h98);
    results;
  end
endmodule // accel_main_control_regs_test
